/* File: mcl_defs.vh */
/*
 * Constants for the motor current limit and hold block: register byte
 * offsets, reset values, ranges of the scaled fields and state codes.
 * Assumes it is included by bare name from each design file.
 */
`ifndef MCL_DEFS_VH
`define MCL_DEFS_VH

// ****************************************************************
// Register byte offsets (one 32-bit word each)
// ****************************************************************
`define MCL_REG_CTRL       8'h00
`define MCL_REG_HOLD_RATE  8'h04
`define MCL_REG_RB_GAIN    8'h08
`define MCL_REG_DRIVE_CAP  8'h0C
`define MCL_REG_REGEN_CAP  8'h10
`define MCL_REG_BRAKE_CAP  8'h14
`define MCL_REG_EMR_CAP    8'h18
`define MCL_REG_ILOCK_CAP  8'h1C
`define MCL_REG_BASE_SPEED 8'h20
`define MCL_REG_SPEED_STEP 8'h24
`define MCL_REG_DMAP0      8'h28
`define MCL_REG_RMAP0      8'h3C
`define MCL_REG_STATUS     8'h50
`define MCL_MAP_POINTS     5

// ****************************************************************
// Field ranges and reset values
// ****************************************************************
`define MCL_CAP_MIN        15'h0666
`define MCL_CAP_MAX        15'h7FFF
`define MCL_RATE_MIN       16'h0032
`define MCL_RATE_MAX       16'h03E8
`define MCL_GAIN_MAX       16'h0800
`define MCL_BASE_MIN       16'h0064
`define MCL_BASE_MAX       16'h0FA0
`define MCL_STEP_MIN       16'h0032
`define MCL_STEP_MAX       16'h03E8
`define MCL_PCT_FULL       15'h7FFF
`define MCL_RST_RATE       16'h01F4
`define MCL_RST_BASE       16'h03E8
`define MCL_RST_STEP       16'h00C8
`define MCL_PCT_SHIFT      15
`define MCL_GAIN_SHIFT     11

// ****************************************************************
// Cap situation codes and hold states
// ****************************************************************
`define MCL_SIT_DRIVE      3'h0
`define MCL_SIT_REGEN      3'h1
`define MCL_SIT_BRAKE      3'h2
`define MCL_SIT_ILOCK      3'h3
`define MCL_SIT_EMR        3'h4
`define MCL_HS_IDLE        2'h0
`define MCL_HS_RAMP        2'h1
`define MCL_HS_HOLD        2'h2

`endif

/* File: mcl_map_interp.v */
/*
 * Speed dependent limiting map: five percentage points at base speed and
 * base plus one, two, four and eight steps, linear between them.
 * Assumes speed magnitude and settings come from logic on clk_i.
 */
`timescale 1ns/100ps
`include "mcl_defs.vh"

module mcl_map_interp #(
    parameter SW = 16
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire [SW-1:0] speed_mag_i,
    input  wire [15:0]   base_i,
    input  wire [15:0]   step_i,
    input  wire [74:0]   points_i,
    output reg  [14:0]   pct_o
);

    // ************************************************************
    // Breakpoints and segment choice
    // ************************************************************
    // Breakpoint k sits at base plus 0,1,2,4,8 steps
    function [19:0] bp;
        input [15:0] b;
        input [15:0] s;
        input [2:0]  k;
        begin
            case (k)
                3'h0:    bp = {4'h0, b};
                3'h1:    bp = {4'h0, b} + {4'h0, s};
                3'h2:    bp = {4'h0, b} + {3'h0, s, 1'b0};
                3'h3:    bp = {4'h0, b} + {2'h0, s, 2'h0};
                default: bp = {4'h0, b} + {1'b0, s, 3'h0};
            endcase
        end
    endfunction

    wire [19:0] spd = {{(20-SW){1'b0}}, speed_mag_i};
    reg  [2:0]  seg;
    reg  [19:0] lo;
    reg  [19:0] hi;
    reg  [14:0] p_lo;
    reg  [14:0] p_hi;
    reg  [14:0] nxt_pct;
    reg  signed [16:0] dp;
    reg  signed [37:0] prod;
    reg  signed [37:0] quo;

    // Interpolate inside the segment; flat outside the map
    always @* begin
        seg = 3'h0;
        if (spd >= bp(base_i, step_i, 3'h1)) seg = 3'h1;
        if (spd >= bp(base_i, step_i, 3'h2)) seg = 3'h2;
        if (spd >= bp(base_i, step_i, 3'h3)) seg = 3'h3;
        lo   = bp(base_i, step_i, seg);
        hi   = bp(base_i, step_i, seg + 3'h1);
        p_lo = points_i[seg*15 +: 15];
        p_hi = points_i[(seg+3'h1)*15 +: 15];
        dp   = $signed({2'b00, p_hi}) - $signed({2'b00, p_lo});
        prod = dp * $signed({1'b0, spd - lo});
        quo  = prod / $signed({1'b0, hi - lo});   // Width is never zero, step >= 1
        if (spd < {4'h0, base_i})
            nxt_pct = points_i[14:0];
        else if (spd >= bp(base_i, step_i, 3'h4))
            nxt_pct = points_i[74:60];
        else
            nxt_pct = p_lo + quo[14:0];
    end

    // Registered percentage output
    always @(posedge clk_i) begin
        if (rst_i)
            pct_o <= `MCL_PCT_FULL;
        else
            pct_o <= nxt_pct;
    end

endmodule

/* File: mcl_hold.v */
/*
 * Hold-in-place entry and rollback feedforward. Produces the speed
 * command during the entry ramp and a torque term during rollback.
 * Assumes speed, position and request words are on clk_i.
 */
`timescale 1ns/100ps
`include "mcl_defs.vh"

module mcl_hold #(
    parameter RAMP_DIV = 125
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        enable_i,
    input  wire [15:0] rate_i,
    input  wire [15:0] gain_i,
    input  wire [15:0] speed_i,
    input  wire [15:0] position_i,
    input  wire [15:0] request_i,
    input  wire        throttle_fwd_i,
    input  wire        preload_off_i,
    input  wire        preload_expired_i,
    output wire        hold_active_o,
    output reg  [15:0] speed_cmd_ff,
    output reg  [15:0] rollback_torque_ff
);

    // ************************************************************
    // Entry state machine
    // ************************************************************
    reg  [1:0]  state_ff;
    reg  [1:0]  dir_ff;
    reg  [15:0] tick_ff;
    reg         rb_ff;
    wire        tick = (tick_ff == RAMP_DIV - 1);
    wire        fwd  = ~speed_i[15] & (speed_i != 16'h0000);
    wire        rev  = speed_i[15];
    wire        flip = (dir_ff == 2'b01 & rev) | (dir_ff == 2'b10 & fwd);
    wire        req0 = (request_i == 16'h0000);
    wire [15:0] mag  = speed_cmd_ff[15] ? -speed_cmd_ff : speed_cmd_ff;

    assign hold_active_o = (state_ff == `MCL_HS_HOLD);

    // Rate steps the command once per tick so the ramp is slow enough to feel
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= `MCL_HS_IDLE;
            dir_ff       <= 2'b00;
            tick_ff      <= 16'h0000;
            speed_cmd_ff <= 16'h0000;
        end else begin
            tick_ff <= tick ? 16'h0000 : tick_ff + 16'h0001;
            if (fwd | rev)
                dir_ff <= {rev, fwd};
            case (state_ff)
                `MCL_HS_IDLE: begin
                    speed_cmd_ff <= request_i;
                    if (enable_i & req0 & flip) begin
                        state_ff     <= `MCL_HS_HOLD;
                        speed_cmd_ff <= 16'h0000;
                    end else if (enable_i & req0) begin
                        state_ff     <= `MCL_HS_RAMP;
                        speed_cmd_ff <= speed_i;
                    end
                end
                `MCL_HS_RAMP: begin
                    if (~req0 | ~enable_i) begin
                        state_ff <= `MCL_HS_IDLE;
                    end else if (flip | mag == 16'h0000) begin
                        state_ff     <= `MCL_HS_HOLD;
                        speed_cmd_ff <= 16'h0000;
                    end else if (tick) begin
                        if (mag <= rate_i)
                            speed_cmd_ff <= 16'h0000;
                        else if (speed_cmd_ff[15])
                            speed_cmd_ff <= speed_cmd_ff + rate_i;
                        else
                            speed_cmd_ff <= speed_cmd_ff - rate_i;
                    end
                end
                `MCL_HS_HOLD: begin
                    speed_cmd_ff <= 16'h0000;
                    if (~req0 | ~enable_i)
                        state_ff <= `MCL_HS_IDLE;
                end
                default: state_ff <= `MCL_HS_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Rollback feedforward
    // ************************************************************
    wire        rb_ok  = preload_off_i | preload_expired_i;
    wire [15:0] rb_pos = position_i[15] ? -position_i : 16'h0000;
    wire [31:0] rb_mul = rb_pos * gain_i;

    // Armed while rolling back under forward throttle once the preload is off or expired; forward speed ends it
    always @(posedge clk_i) begin
        if (rst_i) begin
            rb_ff              <= 1'b0;
            rollback_torque_ff <= 16'h0000;
        end else begin
            rb_ff <= rb_ok & throttle_fwd_i & ~fwd & (rb_ff | rev);
            if (rb_ff & ~fwd)
                rollback_torque_ff <= rb_mul[`MCL_GAIN_SHIFT +: 16];
            else
                rollback_torque_ff <= 16'h0000;
        end
    end

endmodule

/* File: mcl_top.v */
/*
 * Motor current limit and hold block: Wishbone register file, situation
 * cap selection, speed limiting maps and hold-in-place helpers.
 * Assumes classic Wishbone on clk_i; speed/position words come from
 * feedback logic on clk_i; brake, emergency reverse and interlock are pins.
 */
`timescale 1ns/100ps
`include "mcl_defs.vh"

module mcl_top #(
    parameter RAMP_DIV = 125
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output wire        ack_o,
    input  wire [15:0] speed_i,
    input  wire [15:0] position_i,
    input  wire [15:0] ramp_request_i,
    input  wire        throttle_fwd_i,
    input  wire        preload_off_i,
    input  wire        preload_expired_i,
    input  wire        regen_braking_i,
    input  wire        brake_pin_i,
    input  wire        emr_pin_i,
    input  wire        interlock_pin_i,
    output reg  [14:0] current_cap_o,
    output reg  [2:0]  cap_situation_o,
    output wire        hold_active_o,
    output wire [15:0] hold_speed_o,
    output wire [15:0] rollback_torque_o
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Clamp a written value into its legal range
    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo)
                clamp = lo;
            else if (v > hi)
                clamp = hi;
            else
                clamp = v;
        end
    endfunction

    // Merge the low two byte lanes of a write
    function [15:0] merge;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            merge[7:0]  = s[0] ? d[7:0] : old[7:0];
            merge[15:8] = s[1] ? d[15:8] : old[15:8];
        end
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [2:0] pin_s1_ff;
    reg  [2:0] pin_s2_ff;
    reg  [2:0] pin_s3_ff;
    reg  [2:0] pin_ff;
    wire [2:0] pins = {interlock_pin_i, emr_pin_i, brake_pin_i};

    // A change counts only when stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
            pin_s3_ff <= 3'h0;
            pin_ff    <= 3'h0;
        end else begin
            pin_s1_ff <= pins;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
        end
    end

    wire brake_on = pin_ff[0];
    wire emr_on   = pin_ff[1];
    wire ilock_on = pin_ff[2];

    // ************************************************************
    // Register file
    // ************************************************************
    reg        hold_en_ff;
    reg [15:0] rate_ff;
    reg [15:0] gain_ff;
    reg [14:0] drive_cap_ff;
    reg [14:0] regen_cap_ff;
    reg [14:0] brake_cap_ff;
    reg [14:0] emr_cap_ff;
    reg [14:0] ilock_cap_ff;
    reg [15:0] base_ff;
    reg [15:0] step_ff;
    reg [14:0] dmap_ff [0:4];
    reg [14:0] rmap_ff [0:4];
    reg        ack_ff;
    integer    i;

    wire       req = cyc_i & stb_i & ~ack_ff;
    wire       wr  = req & we_i;
    wire [7:0] dm0 = `MCL_REG_DMAP0;
    wire [7:0] rm0 = `MCL_REG_RMAP0;
    wire [7:0] doff = adr_i - dm0;
    wire [7:0] roff = adr_i - rm0;
    wire       in_d = adr_i >= dm0 && adr_i < rm0;
    wire       in_r = adr_i >= rm0 && adr_i < `MCL_REG_STATUS;

    // One wait-free ack per request; ack drops the cycle after it
    assign ack_o = ack_ff;

    // Writes land on the ack edge; caps and speeds are clamped into range
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff       <= 1'b0;
            hold_en_ff   <= 1'b0;
            rate_ff      <= `MCL_RST_RATE;
            gain_ff      <= 16'h0000;
            drive_cap_ff <= `MCL_CAP_MAX;
            regen_cap_ff <= `MCL_CAP_MAX;
            brake_cap_ff <= `MCL_CAP_MAX;
            emr_cap_ff   <= `MCL_CAP_MAX;
            ilock_cap_ff <= `MCL_CAP_MAX;
            base_ff      <= `MCL_RST_BASE;
            step_ff      <= `MCL_RST_STEP;
            for (i = 0; i < `MCL_MAP_POINTS; i = i + 1) begin
                dmap_ff[i] <= `MCL_PCT_FULL;
                rmap_ff[i] <= `MCL_PCT_FULL;
            end
        end else begin
            ack_ff <= req;
            if (wr) begin
                case (adr_i)
                    `MCL_REG_CTRL:       if (sel_i[0]) hold_en_ff <= dat_i[0];
                    `MCL_REG_HOLD_RATE:  rate_ff <= clamp(merge(rate_ff, dat_i, sel_i),
                                                          `MCL_RATE_MIN, `MCL_RATE_MAX);
                    `MCL_REG_RB_GAIN:    gain_ff <= clamp(merge(gain_ff, dat_i, sel_i),
                                                          16'h0000, `MCL_GAIN_MAX);
                    `MCL_REG_DRIVE_CAP:  drive_cap_ff <= capw(drive_cap_ff);
                    `MCL_REG_REGEN_CAP:  regen_cap_ff <= capw(regen_cap_ff);
                    `MCL_REG_BRAKE_CAP:  brake_cap_ff <= capw(brake_cap_ff);
                    `MCL_REG_EMR_CAP:    emr_cap_ff   <= capw(emr_cap_ff);
                    `MCL_REG_ILOCK_CAP:  ilock_cap_ff <= capw(ilock_cap_ff);
                    `MCL_REG_BASE_SPEED: base_ff <= clamp(merge(base_ff, dat_i, sel_i),
                                                          `MCL_BASE_MIN, `MCL_BASE_MAX);
                    `MCL_REG_SPEED_STEP: step_ff <= clamp(merge(step_ff, dat_i, sel_i),
                                                          `MCL_STEP_MIN, `MCL_STEP_MAX);
                    default: begin
                        if (in_d)
                            dmap_ff[doff[4:2]] <= pctw(dmap_ff[doff[4:2]]);
                        if (in_r)
                            rmap_ff[roff[4:2]] <= pctw(rmap_ff[roff[4:2]]);
                    end
                endcase
            end
        end
    end

    // Cap write: merge lanes, clamp to the legal fraction of rated current
    function [14:0] capw;
        input [14:0] old;
        reg   [15:0] m;
        begin
            m    = clamp(merge({1'b0, old}, dat_i, sel_i), {1'b0, `MCL_CAP_MIN}, {1'b0, `MCL_CAP_MAX});
            capw = m[14:0];
        end
    endfunction

    // Map point write: top bit of the half word is dropped
    function [14:0] pctw;
        input [14:0] old;
        reg   [15:0] m;
        begin
            m    = merge({1'b0, old}, dat_i, sel_i);
            pctw = m[14:0];
        end
    endfunction

    // Read mux; unmapped addresses read zero and are acked
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req & ~we_i) begin
            case (adr_i)
                `MCL_REG_CTRL:       dat_o <= {31'h0, hold_en_ff};
                `MCL_REG_HOLD_RATE:  dat_o <= {16'h0, rate_ff};
                `MCL_REG_RB_GAIN:    dat_o <= {16'h0, gain_ff};
                `MCL_REG_DRIVE_CAP:  dat_o <= {17'h0, drive_cap_ff};
                `MCL_REG_REGEN_CAP:  dat_o <= {17'h0, regen_cap_ff};
                `MCL_REG_BRAKE_CAP:  dat_o <= {17'h0, brake_cap_ff};
                `MCL_REG_EMR_CAP:    dat_o <= {17'h0, emr_cap_ff};
                `MCL_REG_ILOCK_CAP:  dat_o <= {17'h0, ilock_cap_ff};
                `MCL_REG_BASE_SPEED: dat_o <= {16'h0, base_ff};
                `MCL_REG_SPEED_STEP: dat_o <= {16'h0, step_ff};
                `MCL_REG_STATUS:     dat_o <= {10'h0, hold_active_o, pin_ff, cap_situation_o, current_cap_o};
                default: begin
                    if (in_d)
                        dat_o <= {17'h0, dmap_ff[doff[4:2]]};
                    else if (in_r)
                        dat_o <= {17'h0, rmap_ff[roff[4:2]]};
                    else
                        dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************
    // Limiting maps
    // ************************************************************
    wire [15:0] spd_mag = speed_i[15] ? -speed_i : speed_i;
    wire [74:0] dpts = {dmap_ff[4], dmap_ff[3], dmap_ff[2], dmap_ff[1], dmap_ff[0]};
    wire [74:0] rpts = {rmap_ff[4], rmap_ff[3], rmap_ff[2], rmap_ff[1], rmap_ff[0]};
    wire [14:0] dpct;
    wire [14:0] rpct;

    // Drive map: breakpoints from base speed and step
    mcl_map_interp #(.SW(16)) u_dmap (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .speed_mag_i (spd_mag),
        .base_i      (base_ff),
        .step_i      (step_ff),
        .points_i    (dpts),
        .pct_o       (dpct)
    );

    // Regen map shares the same breakpoints
    mcl_map_interp #(.SW(16)) u_rmap (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .speed_mag_i (spd_mag),
        .base_i      (base_ff),
        .step_i      (step_ff),
        .points_i    (rpts),
        .pct_o       (rpct)
    );

    // ************************************************************
    // Situation cap selection
    // ************************************************************
    reg  [2:0]  nxt_sit;
    reg  [14:0] sel_cap;
    reg  [14:0] map_pct;
    wire [29:0] scaled = sel_cap * map_pct;

    // Emergency reverse first, then interlock, brake, regen, drive
    always @* begin
        if (emr_on) begin
            nxt_sit = `MCL_SIT_EMR;
            sel_cap = emr_cap_ff;
        end else if (ilock_on) begin
            nxt_sit = `MCL_SIT_ILOCK;
            sel_cap = ilock_cap_ff;
        end else if (brake_on) begin
            nxt_sit = `MCL_SIT_BRAKE;
            sel_cap = brake_cap_ff;
        end else if (regen_braking_i) begin
            nxt_sit = `MCL_SIT_REGEN;
            sel_cap = regen_cap_ff;
        end else begin
            nxt_sit = `MCL_SIT_DRIVE;
            sel_cap = drive_cap_ff;
        end
        // Emergency reverse may drive or brake; the regen input picks the map
        map_pct = (nxt_sit == `MCL_SIT_DRIVE || (emr_on && !regen_braking_i)) ? dpct : rpct;
    end

    // Registered cap is the situational cap scaled by the map percentage
    always @(posedge clk_i) begin
        if (rst_i) begin
            cap_situation_o <= `MCL_SIT_DRIVE;
            current_cap_o   <= 15'h0000;
        end else begin
            cap_situation_o <= nxt_sit;
            current_cap_o   <= scaled[`MCL_PCT_SHIFT +: 15];
        end
    end

    // ************************************************************
    // Hold in place
    // ************************************************************
    // Entry ramp and rollback term
    mcl_hold #(.RAMP_DIV(RAMP_DIV)) u_hold (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .enable_i           (hold_en_ff),
        .rate_i             (rate_ff),
        .gain_i             (gain_ff),
        .speed_i            (speed_i),
        .position_i         (position_i),
        .request_i          (ramp_request_i),
        .throttle_fwd_i     (throttle_fwd_i),
        .preload_off_i      (preload_off_i),
        .preload_expired_i  (preload_expired_i),
        .hold_active_o      (hold_active_o),
        .speed_cmd_ff       (hold_speed_o),
        .rollback_torque_ff (rollback_torque_o)
    );

endmodule

/* File: mcl_fb_model.sv */
/* Feedback model: speed and position words one clock behind the set values.
   Assumes the bench changes the set values just after clk_i edges. */
`timescale 1ns/100ps
module mcl_fb_model (
    input  wire        clk_i,
    input  wire [15:0] speed_set_i,
    input  wire [15:0] pos_set_i,
    output reg  [15:0] speed_o,
    output reg  [15:0] position_o
);
    // One sample of sensor delay, as a real feedback path adds
    always @(posedge clk_i) begin
        speed_o <= speed_set_i;
        position_o <= pos_set_i;
    end
endmodule

/* File: mcl_assertions.sv */
/* Checker for mcl_top: bus answer, cap situation, rollback stop.
   Assumes pins stay steady for eight cycles where it matters. */
`timescale 1ns/100ps
module mcl_assertions (
    input wire clk_i, rst_i, cyc_i, stb_i, ack_o, emr_pin_i, interlock_pin_i, brake_pin_i, regen_braking_i,
    input wire [2:0] cap_situation_o,
    input wire [15:0] speed_i, rollback_torque_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Eight steady cycles cover the pin synchroniser plus the register
    wire [3:0] p = {emr_pin_i, interlock_pin_i, brake_pin_i, regen_braking_i};
    wire [2:0] s = cap_situation_o;
    AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack too long");
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    AST_SIT_EMR: assert property (p[3] [*8] |-> s == 3'h4) else $error("sit");
    AST_SIT_ILOCK: assert property ((p[3:2] == 2'h1) [*8] |-> s == 3'h3) else $error("sit");
    AST_SIT_BRAKE: assert property ((p[3:1] == 3'h1) [*8] |-> s == 3'h2) else $error("sit");
    AST_SIT_REGEN: assert property ((p == 4'h1) [*8] |-> s == 3'h1) else $error("sit");
    AST_SIT_DRIVE: assert property ((p == 4'h0) [*8] |-> s == 3'h0) else $error("sit");
    AST_RB_STOP: assert property (($signed(speed_i) > 0) [*3] |-> rollback_torque_o == 16'h0) else $error("rb");
    cover property (s == 3'h4);
    cover property (s == 3'h3);
    cover property (rollback_torque_o != 16'h0);
endmodule
bind mcl_top mcl_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .emr_pin_i(emr_pin_i), .interlock_pin_i(interlock_pin_i), .brake_pin_i(brake_pin_i),
    .regen_braking_i(regen_braking_i), .cap_situation_o(cap_situation_o), .speed_i(speed_i),
    .rollback_torque_o(rollback_torque_o));

/* File: mcl_top_tb.sv */
/* Bench for mcl_top: Wishbone tasks, pin, request and feedback stimulus.
   Assumes mcl_fb_model and the bound checker. */
`timescale 1ns/100ps
module mcl_top_tb;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, throttle_fwd_i = 0, preload_off_i = 0;
    reg preload_expired_i = 0, regen_braking_i = 0, brake_pin_i = 0, emr_pin_i = 0, interlock_pin_i = 0;
    reg [7:0] adr_i = 8'h0;
    reg [3:0] sel_i = 4'hF;
    reg [31:0] dat_i = 32'h0, q;
    reg [15:0] spd = 16'h0, pos = 16'h0, ramp_request_i = 16'h0;
    wire [31:0] dat_o;
    wire [15:0] speed_i, position_i, hold_speed_o, rollback_torque_o;
    wire [14:0] current_cap_o;
    wire [2:0] cap_situation_o;
    wire ack_o, hold_active_o;
    integer bad_count = 0, tests_run = 0, k;
    always #4 clk_i = ~clk_i;
    mcl_fb_model fb (.clk_i(clk_i), .speed_set_i(spd), .pos_set_i(pos), .speed_o(speed_i), .position_o(position_i));
    mcl_top #(.RAMP_DIV(2)) uut (.*);
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (e !== g) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Waits as long as the slave needs; only the watchdog ends a silent slave
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            chk("ack", 1, ack_o);
            q = dat_o;
            {cyc_i, stb_i} <= 2'h0;
        end
    endtask
    task rw(input w, input [7:0] a, input [31:0] d, input [31:0] e);
        begin
            if (w) wb(1'b1, a, d);
            wb(1'b0, a, 32'h0);
            chk("rdback", e, q);
        end
    endtask
    task wt(input integer c);
        repeat (c) @(posedge clk_i);
    endtask
    // Cap scaled by a map percentage, truncated
    function [14:0] sc(input [14:0] c, input [14:0] p);
        sc = ({15'h0, c} * {15'h0, p}) >> 15;
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #80000;
        bad_count = bad_count + 1;
        results;
    end
    // Main sequence: registers, situations, map, rollback, hold
    initial begin
        wt(6);
        rst_i <= 1'b0;
        rw(0, 8'h20, 0, 32'h3E8);
        rw(0, 8'h24, 0, 32'hC8);
        rw(1, 8'h0C, 32'h10, 32'h666);
        rw(1, 8'h04, 32'h32, 32'h32);
        rw(1, 8'h08, 32'hFFFF, 32'h800);
        rw(1, 8'h60, 32'h5A5A, 32'h0);
        sel_i <= 4'h0;
        rw(1, 8'h24, 32'h64, 32'hC8);
        sel_i <= 4'hF;
        // Each pass adds a cause, so precedence is seen with lower causes present
        for (k = 0; k < 5; k = k + 1) begin
            wb(1, (k == 3) ? 8'h1C : (k == 4) ? 8'h18 : 8'h0C + 4 * k, 32'h1000 * (k + 1));
            {emr_pin_i, interlock_pin_i, brake_pin_i, regen_braking_i} <= (4'h1 << k) - 1;
            wt(12);
            chk("sit", k, cap_situation_o);
            chk("cap", sc(15'h1000 * (k + 1), 15'h7FFF), current_cap_o);
        end
        {emr_pin_i, interlock_pin_i, brake_pin_i, regen_braking_i} <= 4'h0;
        wb(1, 8'h28, 32'h4000);
        wb(1, 8'h38, 32'h2000);
        wt(12);
        chk("map0", sc(15'h1000, 15'h4000), current_cap_o);
        spd <= 16'hFBB4;
        wt(12);
        chk("mapmid", sc(15'h1000, 15'h5FFF), current_cap_o);
        spd <= 16'h0A28;
        wt(12);
        chk("map4", sc(15'h1000, 15'h2000), current_cap_o);
        // Reverse cap driving uses the drive map, braking the regen map
        emr_pin_i <= 1;
        wt(12);
        chk("revdrv", sc(15'h5000, 15'h2000), current_cap_o);
        regen_braking_i <= 1;
        wt(12);
        chk("revreg", sc(15'h5000, 15'h7FFF), current_cap_o);
        {emr_pin_i, regen_braking_i} <= 2'h0;
        throttle_fwd_i <= 1;
        spd <= 16'hFFF6;
        pos <= 16'hFF00;
        wt(8);
        chk("torque", 0, rollback_torque_o);
        preload_expired_i <= 1;
        wt(8);
        chk("torque", 32'h100, rollback_torque_o);
        spd <= 16'h000A;
        wt(8);
        chk("torque", 0, rollback_torque_o);
        {preload_expired_i, preload_off_i} <= 2'h1;
        spd <= 16'hFFF6;
        wt(8);
        chk("torque", 32'h100, rollback_torque_o);
        wb(1, 8'h00, 32'h1);
        ramp_request_i <= 16'h03E8;
        spd <= 16'h03E8;
        wt(8);
        ramp_request_i <= 16'h0;
        spd <= 16'hFFFB;
        wt(4);
        chk("hold", 1, hold_active_o);
        ramp_request_i <= 16'h012C;
        spd <= 16'h012C;
        wt(8);
        ramp_request_i <= 16'h0;
        wt(3);
        chk("hold", 0, hold_active_o);
        wt(30);
        chk("hold", 1, hold_active_o);
        chk("holdspd", 0, hold_speed_o);
        rw(0, 8'h50, 0, 32'h200800);
        results;
    end
endmodule
